/* kmon_top.sv */
// Motor fault shutdown monitor with Wishbone register file
//
// Operation
// - Only status bits whose enable bit is one are evaluated.
// - Enabled bits compare against their condition-state level.
// - Any single matching enabled condition starts a shutdown.
// - Three enable/state pairs: primary, secondary, extended I/O words.
// - Over-voltage with driver on always disables the driver.
// - Motor windings shorted while over-voltage persists.
// - Primary word bit 4 I/O1, bit 7 over-temp low-true, bit 8.
// - Opcode 167 loads primary enable and state; ack without data.
// - Recovery zero aborts motion, goes idle, disables driver.
// - Recovery minus one runs the program at address zero.
// - Other recovery values run the program at that address.
// - Processor supply checked against its own low-voltage threshold.
// - Low supply sets status bit 14 and starts power-low recovery.
// - Any low-voltage trip zeroes both thresholds.
// - Processor threshold zero or 10 to 48 volts, default zero.
// - Driver threshold zero or 10 to 48 volts, default ten.
// - Keep-driver option plus multitasking keeps driver on at kill.
`timescale 1ns/10ps
`default_nettype none
module kmon_top #(
  parameter int SW_W   = kmon_pkg::SW_W,
  parameter int VOLT_W = kmon_pkg::VOLT_W
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Monitored words and supplies
  input  wire logic [SW_W-1:0]   primary_status_word_i,
  input  wire logic [SW_W-1:0]   secondary_status_word_i,
  input  wire logic [SW_W-1:0]   extended_io_word_i,
  input  wire logic              over_voltage_i,
  input  wire logic              multitask_i,
  input  wire logic [VOLT_W-1:0] driver_volts_i,
  input  wire logic [VOLT_W-1:0] proc_volts_i,
  // Shutdown actions
  output logic                   driver_en_o,
  output logic                   short_windings_o,
  output logic                   abort_motion_o,
  output logic                   recovery_start_o,
  output logic      [15:0]       recovery_addr_o,
  output logic                   power_low_start_o,
  output logic                   low_volt_status_o,
  output logic                   irq_o
);
  if (SW_W != 16 || VOLT_W < 6 || VOLT_W > 16) begin : g_bad_cfg
    $error("kmon_top: SW_W must be 16 and VOLT_W 6 to 16");
  end

  // Register state
  logic [SW_W-1:0]   cond_en  [3];
  logic [SW_W-1:0]   cond_st  [3];
  logic [15:0]       param    [kmon_pkg::N_PARAM];
  logic [15:0]       recov_sel;
  logic [VOLT_W-1:0] lv_drv;
  logic [VOLT_W-1:0] lv_proc;
  logic              keep_drv;
  logic              plr_cfg;
  logic [7:0]        last_opc;
  logic [kmon_pkg::IRQ_W-1:0] irq_stat;
  logic [kmon_pkg::IRQ_W-1:0] irq_mask;
  logic              kill_hit;
  kmon_pkg::kmon_state_e state;

  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic [15:0] wdat;
  logic [5:0]  widx;
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign wdat = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                 wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  assign widx = wb_adr_i[7:2];

  logic wr_ctrl;
  logic wr_cmd;
  logic [7:0] opc;
  assign wr_ctrl = wr_en && (wb_adr_i == kmon_pkg::OFS_CTRL);
  assign wr_cmd = wr_en && (wb_adr_i == kmon_pkg::OFS_CMD);
  assign opc = wdat[7:0];

  // Range check for threshold parameters
  logic lv_ok;
  assign lv_ok = (param[0] == 16'h0000)
    || (param[0] >= 16'(kmon_pkg::LV_MIN)
        && param[0] <= 16'(kmon_pkg::LV_MAX));
  logic opc_known;
  assign opc_known = (opc == kmon_pkg::OPC_KILL_COND)
    || (opc == kmon_pkg::OPC_KILL_EXT) || (opc == kmon_pkg::OPC_KILL_RECOV)
    || (opc == kmon_pkg::OPC_KEEP_DRV) || (opc == kmon_pkg::OPC_DROP_DRV)
    || (opc == kmon_pkg::OPC_PROC_LV) || (opc == kmon_pkg::OPC_DRV_LV);
  logic cmd_err;
  assign cmd_err = wr_cmd && (!opc_known
    || ((opc == kmon_pkg::OPC_PROC_LV || opc == kmon_pkg::OPC_DRV_LV)
        && !lv_ok));

  // Condition matching per word
  logic [SW_W-1:0] mon_word [3];
  logic [2:0]      word_hit;
  always_comb begin
    mon_word[0] = primary_status_word_i;
    mon_word[0][kmon_pkg::PSW_LOW_V_BIT] = low_volt_status_o;
    mon_word[1] = secondary_status_word_i;
    mon_word[2] = extended_io_word_i;
  end

  for (genvar w = 0; w < 3; w++) begin : g_word
    kmon_match #(.W(SW_W)) u_match (
      .word_i   (mon_word[w]),
      .enable_i (cond_en[w]),
      .state_i  (cond_st[w]),
      .hit_o    (word_hit[w])
    );
  end

  // Registered trigger
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      kill_hit <= 1'b0;
    end else begin
      kill_hit <= |word_hit;
    end
  end

  // Parameter staging registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < kmon_pkg::N_PARAM; i++) begin
        param[i] <= 16'h0000;
      end
    end else if (wr_en && widx >= kmon_pkg::OFS_PARAM0[7:2]
                 && widx < kmon_pkg::OFS_PARAM0[7:2] + 6'(kmon_pkg::N_PARAM))
    begin
      param[3'(widx - kmon_pkg::OFS_PARAM0[7:2])] <= wdat;
    end
  end

  // Kill condition pairs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cond_en[0] <= kmon_pkg::RST_EN0;
      cond_st[0] <= kmon_pkg::RST_ST0;
      for (int i = 1; i < 3; i++) begin
        cond_en[i] <= 16'h0000;
        cond_st[i] <= 16'h0000;
      end
    end else if (wr_cmd && opc == kmon_pkg::OPC_KILL_COND) begin
      cond_en[0] <= param[0];
      cond_st[0] <= param[1];
    end else if (wr_cmd && opc == kmon_pkg::OPC_KILL_EXT) begin
      for (int i = 0; i < 3; i++) begin
        cond_en[i] <= param[2*i];
        cond_st[i] <= param[2*i+1];
      end
    end
  end

  // Recovery selection, driver options, last opcode
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      recov_sel <= kmon_pkg::RST_RECOV;
      keep_drv <= 1'b0;
      plr_cfg <= 1'b0;
      last_opc <= 8'h00;
    end else begin
      if (wr_cmd && !cmd_err) begin
        last_opc <= opc;
      end
      if (wr_cmd && opc == kmon_pkg::OPC_KILL_RECOV) begin
        recov_sel <= param[0];
      end
      if (wr_cmd && opc == kmon_pkg::OPC_KEEP_DRV) begin
        keep_drv <= 1'b1;
      end else if (wr_cmd && opc == kmon_pkg::OPC_DROP_DRV) begin
        keep_drv <= 1'b0;
      end
      if (wr_ctrl) begin
        plr_cfg <= wdat[kmon_pkg::CTRL_PLR_CFG];
      end
    end
  end

  // Low-voltage monitoring
  logic drv_trip;
  logic proc_trip;
  logic lv_trip;
  kmon_lvtrip #(.VW(VOLT_W)) u_lv_drv (
    .volts_i  (driver_volts_i),
    .thresh_i (lv_drv),
    .trip_o   (drv_trip)
  );
  kmon_lvtrip #(.VW(VOLT_W)) u_lv_proc (
    .volts_i  (proc_volts_i),
    .thresh_i (lv_proc),
    .trip_o   (proc_trip)
  );
  assign lv_trip = drv_trip | proc_trip;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lv_drv <= kmon_pkg::RST_LV_DRV;
      lv_proc <= kmon_pkg::RST_LV_PROC;
    end else if (lv_trip) begin
      lv_drv <= '0;
      lv_proc <= '0;
    end else if (wr_cmd && !cmd_err) begin
      if (opc == kmon_pkg::OPC_DRV_LV) begin
        lv_drv <= param[0][VOLT_W-1:0];
      end
      if (opc == kmon_pkg::OPC_PROC_LV) begin
        lv_proc <= param[0][VOLT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_volt_status_o <= 1'b0;
      power_low_start_o <= 1'b0;
    end else begin
      power_low_start_o <= lv_trip & plr_cfg;
      if (lv_trip) begin
        low_volt_status_o <= 1'b1;
      end else if (wr_ctrl && wdat[kmon_pkg::CTRL_LV_CLR]) begin
        low_volt_status_o <= 1'b0;
      end
    end
  end

  // Shutdown sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= kmon_pkg::KMON_RUN;
    end else begin
      case (state)
        kmon_pkg::KMON_RUN: begin
          if (kill_hit) state <= kmon_pkg::KMON_KILL;
        end
        kmon_pkg::KMON_KILL: begin
          state <= kmon_pkg::KMON_HALT;
        end
        kmon_pkg::KMON_HALT: begin
          if (!kill_hit) state <= kmon_pkg::KMON_RUN;
        end
        default: state <= kmon_pkg::KMON_RUN;
      endcase
    end
  end

  logic in_kill;
  assign in_kill = (state == kmon_pkg::KMON_KILL);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      abort_motion_o <= 1'b0;
      recovery_start_o <= 1'b0;
      recovery_addr_o <= 16'h0000;
    end else begin
      abort_motion_o <= in_kill;
      recovery_start_o <= in_kill && (recov_sel != 16'h0000);
      if (in_kill && recov_sel == kmon_pkg::RECOV_INIT) begin
        recovery_addr_o <= kmon_pkg::RECOV_INIT_ADR;
      end else if (in_kill && recov_sel != 16'h0000) begin
        recovery_addr_o <= recov_sel;
      end
    end
  end

  // Motor driver enable and winding short
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      driver_en_o <= 1'b0;
    end else if (over_voltage_i && driver_en_o) begin
      driver_en_o <= 1'b0;
    end else if (in_kill && !(keep_drv && multitask_i)) begin
      driver_en_o <= 1'b0;
    end else if (wr_ctrl && wdat[kmon_pkg::CTRL_DRV_ON]) begin
      driver_en_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      short_windings_o <= 1'b0;
    end else begin
      short_windings_o <= over_voltage_i
        && (driver_en_o || short_windings_o);
    end
  end

  // Interrupt status, mask and output
  logic [kmon_pkg::IRQ_W-1:0] irq_set;
  always_comb begin
    irq_set = '0;
    irq_set[kmon_pkg::IRQ_KILL] = in_kill;
    irq_set[kmon_pkg::IRQ_OVER_V] = over_voltage_i & driver_en_o;
    irq_set[kmon_pkg::IRQ_LOW_V] = lv_trip;
    irq_set[kmon_pkg::IRQ_CMD_ERR] = cmd_err;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq_o <= 1'b0;
    end else begin
      if (wr_en && wb_adr_i == kmon_pkg::OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wdat[kmon_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      if (wr_en && wb_adr_i == kmon_pkg::OFS_IRQ_MASK) begin
        irq_mask <= wdat[kmon_pkg::IRQ_W-1:0];
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Read mux and acknowledge
  logic [31:0] rdat;
  always_comb begin
    rdat = 32'h0000_0000;
    case (wb_adr_i)
      kmon_pkg::OFS_CTRL:     rdat = {30'h0, plr_cfg, driver_en_o};
      kmon_pkg::OFS_CMD:      rdat = {24'h0, last_opc};
      kmon_pkg::OFS_STATE:    rdat = {24'h0, short_windings_o,
                                      low_volt_status_o, keep_drv, kill_hit,
                                      1'b0, state};
      kmon_pkg::OFS_IRQ_STAT: rdat = {28'h0, irq_stat};
      kmon_pkg::OFS_IRQ_MASK: rdat = {28'h0, irq_mask};
      kmon_pkg::OFS_RECOV:    rdat = {16'h0, recov_sel};
      kmon_pkg::OFS_LV_DRV:   rdat = {24'h0, 8'(lv_drv)};
      kmon_pkg::OFS_LV_PROC:  rdat = {24'h0, 8'(lv_proc)};
      default: begin
        if (widx >= kmon_pkg::OFS_COND0[7:2]
            && widx < kmon_pkg::OFS_COND0[7:2] + 6'd6) begin
          if (widx[0] == kmon_pkg::OFS_COND0[2]) begin
            rdat = {16'h0, cond_en[2'((widx - kmon_pkg::OFS_COND0[7:2]) >> 1)]};
          end else begin
            rdat = {16'h0, cond_st[2'((widx - kmon_pkg::OFS_COND0[7:2]) >> 1)]};
          end
        end else if (widx >= kmon_pkg::OFS_PARAM0[7:2]
                     && widx < kmon_pkg::OFS_PARAM0[7:2] + 6'd6) begin
          rdat = {16'h0, param[3'(widx - kmon_pkg::OFS_PARAM0[7:2])]};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_en) begin
        wb_dat_o <= rdat;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ovp_drv_off: assert property (over_voltage_i && driver_en_o
    |=> !driver_en_o) else $error("driver stayed on during over-voltage");
  a_short_cause: assert property (short_windings_o
    |-> $past(over_voltage_i))
    else $error("windings shorted without over-voltage");
  a_trigger_reg: assert property (kill_hit == $past(|word_hit))
    else $error("kill trigger not registered from matches");
  a_mask_ignore: assert property (
    (cond_en[0] == '0 && cond_en[1] == '0 && cond_en[2] == '0)[*2]
    |-> !kill_hit) else $error("kill trigger with all conditions masked");
  a_kill_drv: assert property (
    in_kill && !(keep_drv && multitask_i) |=> !driver_en_o)
    else $error("driver left on after kill");
  a_kill_seq: assert property (
    state == kmon_pkg::KMON_RUN && kill_hit |=> in_kill ##1 abort_motion_o)
    else $error("shutdown not started on matched condition");
  a_recov_init: assert property (
    in_kill && recov_sel == kmon_pkg::RECOV_INIT
    |=> recovery_start_o && recovery_addr_o == 16'h0000)
    else $error("init recovery not started at address zero");
  a_recov_adr: assert property (
    in_kill && recov_sel != 16'h0000 && recov_sel != kmon_pkg::RECOV_INIT
    |=> recovery_start_o && recovery_addr_o == $past(recov_sel))
    else $error("recovery not started at selected address");
  a_recov_none: assert property (
    in_kill && recov_sel == 16'h0000 |=> !recovery_start_o)
    else $error("recovery started with selection zero");
  a_lv_zero: assert property (
    lv_trip |=> lv_drv == '0 && lv_proc == '0 && low_volt_status_o)
    else $error("thresholds not cleared after low-voltage trip");
  a_kmc_load: assert property (
    wr_cmd && opc == kmon_pkg::OPC_KILL_COND
    |=> cond_en[0] == $past(param[0]) && cond_st[0] == $past(param[1]))
    else $error("primary kill pair not loaded");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_kill_recov: cover property (in_kill && recov_sel != 16'h0000);
  c_over_v: cover property (short_windings_o [*3]);
  c_low_v: cover property (lv_trip && plr_cfg);
endmodule : kmon_top
`default_nettype wire

/* kmon_pkg.sv */
// Package of constants for the motor fault shutdown monitor
`default_nettype none
package kmon_pkg;
  // Word and bus widths
  localparam int SW_W = 16;
  localparam int VOLT_W = 8;
  localparam int ADR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_PARAM0 = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_COND0 = 8'h30;
  localparam logic [7:0] OFS_RECOV = 8'h48;
  localparam logic [7:0] OFS_LV_DRV = 8'h4C;
  localparam logic [7:0] OFS_LV_PROC = 8'h50;
  localparam int N_PARAM = 6;
  // Control register fields
  localparam int CTRL_DRV_ON = 0;
  localparam int CTRL_PLR_CFG = 1;
  localparam int CTRL_LV_CLR = 2;
  // Interrupt status fields
  localparam int IRQ_W = 4;
  localparam int IRQ_KILL = 0;
  localparam int IRQ_OVER_V = 1;
  localparam int IRQ_LOW_V = 2;
  localparam int IRQ_CMD_ERR = 3;
  // Command opcodes
  localparam logic [7:0] OPC_KILL_COND = 8'hA7;
  localparam logic [7:0] OPC_KILL_EXT = 8'hDC;
  localparam logic [7:0] OPC_KILL_RECOV = 8'hB5;
  localparam logic [7:0] OPC_KEEP_DRV = 8'hB6;
  localparam logic [7:0] OPC_DROP_DRV = 8'hB7;
  localparam logic [7:0] OPC_PROC_LV = 8'h83;
  localparam logic [7:0] OPC_DRV_LV = 8'hD4;
  // Primary status word bit positions
  localparam int PSW_IO1_BIT = 4;
  localparam int PSW_OVERTEMP_BIT = 7;
  localparam int PSW_MOVERR_BIT = 8;
  localparam int PSW_LOW_V_BIT = 14;
  // Reset values, init recovery selector and address, threshold range limits
  localparam logic [15:0] RST_EN0 = 16'h0080;
  localparam logic [15:0] RST_ST0 = 16'h0000;
  localparam logic [15:0] RST_RECOV = 16'h0000;
  localparam logic [15:0] RECOV_INIT = 16'hFFFF;
  localparam logic [15:0] RECOV_INIT_ADR = 16'h0000;
  localparam logic [7:0] RST_LV_DRV = 8'h0A;
  localparam logic [7:0] RST_LV_PROC = 8'h00;
  localparam logic [7:0] LV_MIN = 8'h0A;
  localparam logic [7:0] LV_MAX = 8'h30;
  // Shutdown sequencer states
  typedef enum logic [2:0] {
    KMON_RUN  = 3'b001,
    KMON_KILL = 3'b010,
    KMON_HALT = 3'b100
  } kmon_state_e;
endpackage : kmon_pkg
`default_nettype wire

/* kmon_match.sv */
// Kill condition match over one status word
`timescale 1ns/10ps
`default_nettype none
module kmon_match #(
  parameter int W = 16
) (
  // Word, enable mask and condition state
  input  wire logic [W-1:0] word_i,
  input  wire logic [W-1:0] enable_i,
  input  wire logic [W-1:0] state_i,
  // Any enabled bit at its condition level
  output logic              hit_o
);
  logic [W-1:0] bit_hit;

  if (W < 1) begin : g_bad_w
    $error("kmon_match: W must be positive");
  end

  for (genvar b = 0; b < W; b++) begin : g_bit
    assign bit_hit[b] = enable_i[b] & ~(word_i[b] ^ state_i[b]);
  end

  assign hit_o = |bit_hit;
endmodule : kmon_match
`default_nettype wire

/* kmon_lvtrip.sv */
// Low-voltage comparison for one supply
`timescale 1ns/10ps
`default_nettype none
module kmon_lvtrip #(
  parameter int VW = 8
) (
  // Measured supply and trip threshold in whole volts
  input  wire logic [VW-1:0] volts_i,
  input  wire logic [VW-1:0] thresh_i,
  // Supply below a nonzero threshold
  output logic               trip_o
);
  if (VW < 6) begin : g_bad_vw
    $error("kmon_lvtrip: VW too narrow for 48 V");
  end

  assign trip_o = (thresh_i != '0) && (volts_i < thresh_i);
endmodule : kmon_lvtrip
`default_nettype wire

/* kmon_host.sv */
// Wishbone host model issuing register accesses
`timescale 1ns/10ps
`default_nettype none
module kmon_host (
  // Clock
  input  wire logic        clk_i,
  // Wishbone master
  output var  logic        wb_cyc_o,
  output var  logic        wb_stb_o,
  output var  logic        wb_we_o,
  output var  logic [7:0]  wb_adr_o,
  output var  logic [3:0]  wb_sel_o,
  output var  logic [31:0] wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  int tmo;

  initial begin
    tmo = 0;
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0000_0000;
  end

  // One classic cycle, held until ack, released at that edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 20);
    if (n >= 20) tmo++;
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
  endtask : xfer
endmodule : kmon_host
`default_nettype wire

/* kmon_tb.sv */
// Testbench for the motor fault shutdown monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, rst_n, cyc, stb, we, ack, ot, mt;
  logic        den, shrt, abrt, rs, plow, lvs, irq, hit, rec;
  logic [7:0]  adr, dv, pv;
  logic [3:0]  sel;
  logic [31:0] wd, rdat, q;
  logic [15:0] pw, sw, xw, ra, raddr;
  int          fails, num_checks;
  logic [15:0] kv [4] = '{16'h0091, 16'h0080, 16'h0010, 16'h0190};
  logic        ke [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

  initial clk = 1'b0;
  always #10 clk = ~clk;

  kmon_top DUT (.clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .primary_status_word_i(pw), .secondary_status_word_i(sw),
    .extended_io_word_i(xw), .over_voltage_i(ot), .multitask_i(mt),
    .driver_volts_i(dv), .proc_volts_i(pv), .driver_en_o(den),
    .short_windings_o(shrt), .abort_motion_o(abrt),
    .recovery_start_o(rs), .recovery_addr_o(raddr),
    .power_low_start_o(plow), .low_volt_status_o(lvs), .irq_o(irq));

  kmon_host host (.clk_i(clk), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wd),
    .wb_dat_i(rdat), .wb_ack_i(ack));

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic chb(string n, logic e, logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chb

  task automatic wr(logic [7:0] a, logic [31:0] d);
    host.xfer(1'b1, a, d, q);
    if (host.tmo != 0) end_sim();
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    if (host.tmo != 0) end_sim();
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  task automatic cmd(logic [7:0] op, logic [15:0] a, logic [15:0] b);
    wr(kmon_pkg::OFS_PARAM0, {16'h0, a});
    wr(kmon_pkg::OFS_PARAM0 + 8'h04, {16'h0, b});
    wr(kmon_pkg::OFS_CMD, {24'h0, op});
  endtask : cmd

  // Apply words, watch shutdown pulses for a bounded window
  task automatic fire(logic [15:0] p, logic [15:0] s, logic [15:0] x);
    pw <= p;
    sw <= s;
    xw <= x;
    hit = 1'b0;
    rec = 1'b0;
    repeat (8) begin
      @(posedge clk);
      if (abrt === 1'b1) hit = 1'b1;
      if (rs === 1'b1) begin
        rec = 1'b1;
        ra = raddr;
      end
    end
  endtask : fire

  task automatic calm();
    pw <= 16'h0090;
    sw <= 16'h0000;
    xw <= 16'h0000;
    repeat (4) @(posedge clk);
    wr(kmon_pkg::OFS_CTRL, 32'h0000_0001);
  endtask : calm

  task automatic wplow();
    hit = 1'b0;
    repeat (8) begin
      @(posedge clk);
      if (plow === 1'b1) hit = 1'b1;
    end
  endtask : wplow

  task automatic end_sim();
    fails += host.tmo;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    ot = 1'b0;
    mt = 1'b0;
    dv = 8'h32;
    pv = 8'h18;
    pw = 16'h0090;
    sw = 16'h0000;
    xw = 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(kmon_pkg::OFS_LV_DRV, 32'h0000_000A);
    rd(kmon_pkg::OFS_LV_PROC, 32'h0000_0000);
    rd(kmon_pkg::OFS_COND0, 32'h0000_0080);
    rd(kmon_pkg::OFS_RECOV, 32'h0000_0000);
    rd(8'hFC, 32'h0000_0000);
    $display("test reset done");
    calm();
    chb("drv_en", 1'b1, den);
    cmd(kmon_pkg::OPC_KILL_COND, 16'h0190, 16'h0100);
    rd(kmon_pkg::OFS_COND0, 32'h0000_0190);
    rd(kmon_pkg::OFS_COND0 + 8'h04, 32'h0000_0100);
    for (int i = 0; i < 4; i++) begin
      fire(kv[i], 16'h0000, 16'h0000);
      chb("kill", ke[i], hit);
      chb("recov", 1'b0, rec);
      chb("drv_en", ~ke[i], den);
      calm();
    end
    $display("test primary done");
    wr(kmon_pkg::OFS_PARAM0 + 8'h08, 32'h0000_0001);
    wr(kmon_pkg::OFS_PARAM0 + 8'h0C, 32'h0000_0001);
    wr(kmon_pkg::OFS_PARAM0 + 8'h10, 32'h0000_8000);
    wr(kmon_pkg::OFS_PARAM0 + 8'h14, 32'h0000_8000);
    cmd(kmon_pkg::OPC_KILL_EXT, 16'h0000, 16'h0000);
    rd(kmon_pkg::OFS_COND0 + 8'h08, 32'h0000_0001);
    fire(16'h0000, 16'h0001, 16'h0000);
    chb("kill sec", 1'b1, hit);
    calm();
    fire(16'h0000, 16'h0000, 16'h8000);
    chb("kill ext", 1'b1, hit);
    calm();
    $display("test extended done");
    for (int i = 0; i < 2; i++) begin
      cmd(kmon_pkg::OPC_KILL_RECOV, i ? 16'h021E : 16'hFFFF, 16'h0000);
      rd(kmon_pkg::OFS_RECOV, i ? 32'h0000_021E : 32'h0000_FFFF);
      fire(16'h0000, 16'h0001, 16'h0000);
      chb("recov", 1'b1, rec);
      chk("recov adr", i ? 32'h021E : 32'h0000, {16'h0, ra});
      calm();
    end
    $display("test recovery done");
    cmd(kmon_pkg::OPC_KEEP_DRV, 16'h0000, 16'h0000);
    mt <= 1'b1;
    fire(16'h0000, 16'h0001, 16'h0000);
    chb("keep drv", 1'b1, den);
    calm();
    ot <= 1'b1;
    repeat (3) @(posedge clk);
    chb("ov drv", 1'b0, den);
    chb("ov short", 1'b1, shrt);
    ot <= 1'b0;
    repeat (3) @(posedge clk);
    chb("ov short", 1'b0, shrt);
    mt <= 1'b0;
    calm();
    fire(16'h0000, 16'h0001, 16'h0000);
    chb("keep no mt", 1'b0, den);
    calm();
    cmd(kmon_pkg::OPC_DROP_DRV, 16'h0000, 16'h0000);
    rd(kmon_pkg::OFS_STATE, 32'h0000_0001);
    $display("test driver done");
    rd(kmon_pkg::OFS_IRQ_STAT, 32'h0000_0003);
    chb("irq", 1'b0, irq);
    wr(kmon_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chb("irq", 1'b1, irq);
    wr(kmon_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chb("irq", 1'b0, irq);
    $display("test irq done");
    wr(kmon_pkg::OFS_CTRL, 32'h0000_0003);
    cmd(kmon_pkg::OPC_PROC_LV, 16'h0031, 16'h0000);
    rd(kmon_pkg::OFS_LV_PROC, 32'h0000_0000);
    rd(kmon_pkg::OFS_IRQ_STAT, 32'h0000_000A);
    rd(kmon_pkg::OFS_CMD, 32'h0000_00B7);
    cmd(kmon_pkg::OPC_PROC_LV, 16'h0014, 16'h0000);
    rd(kmon_pkg::OFS_LV_PROC, 32'h0000_0014);
    pv <= 8'h0F;
    wplow();
    chb("plow proc", 1'b1, hit);
    chb("lv status", 1'b1, lvs);
    rd(kmon_pkg::OFS_LV_DRV, 32'h0000_0000);
    rd(kmon_pkg::OFS_LV_PROC, 32'h0000_0000);
    wr(kmon_pkg::OFS_CTRL, 32'h0000_0006);
    repeat (2) @(posedge clk);
    chb("lv status", 1'b0, lvs);
    cmd(kmon_pkg::OPC_DRV_LV, 16'h0030, 16'h0000);
    rd(kmon_pkg::OFS_LV_DRV, 32'h0000_0030);
    dv <= 8'h2F;
    wplow();
    chb("plow drv", 1'b1, hit);
    rd(kmon_pkg::OFS_LV_DRV, 32'h0000_0000);
    $display("test low voltage done");
    for (int i = 2; i < 6; i++) begin
      wr(kmon_pkg::OFS_PARAM0 + 8'(4 * i), 32'h0000_0000);
    end
    cmd(kmon_pkg::OPC_KILL_EXT, 16'h0000, 16'h0000);
    fire(16'h0000, 16'h0000, 16'h0000);
    chb("all masked", 1'b0, hit);
    $display("test masked done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
